// ### verilog/scq_ctrl_event.sv
`timescale 1ns/100ps
`include "scq_defines.svh"
// How it works
// - Legacy mode uses guest byte order for multi-byte fields.
// - Type 0 is task management; subtypes 0..7 select the function.
// - Fields irrelevant to the chosen function are ignored.
// - Unit address in request format; unit field ignored for nexus-wide functions.
// - Command identifier matched against outstanding commands where relevant.
// - Outcome written to response byte, mapped to standard outcomes.
// - Unit or nexus reset completes all matching commands with reset code.
// - Abort task or task set completes selected commands with aborted code.
// - All caused completions are issued before the function's own response.
// - Query returns the supported subset of the requested mask and response byte.
// - Event masks are one-hot; operational change 2, media change 16.
// - Subscribe records the supported subset of the requested mask for the unit and returns it.
// - Events are dropped when no event buffer is posted.
// - Bit 31 of event code set when earlier events were lost.
// - Code 0 written into short buffers, or to flag losses.
// - Code 1 reasons: 0 hard reset, 1 appeared, 2 removed.
// - Removed or rescan events only with hot-plug negotiated.
// - Reset events also raised as sense data on the unit.
// - Async notify reason holds only subscribed events.
// - Code 3 reason carries asc in bits 0-7, ascq in 8-15.
// - Parameter change never emitted for peripheral type 5.
module scq_ctrl_event
    import scq_pkg::*;
#(
    parameter int SLOTS = 16,
    parameter int UNITS = 16
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic legacy,
    input wire logic guest_big_endian,
    input wire logic hot_plug_feature,
    input wire logic [31:0] supported_events,
    // Control request
    input wire logic ctrl_valid,
    input wire logic [31:0] ctrl_type,
    input wire logic [31:0] ctrl_subtype,
    input wire logic [63:0] ctrl_lun,
    input wire logic [63:0] ctrl_id,
    input wire logic [31:0] ctrl_event_requested,
    output logic ctrl_done,
    output logic [7:0] ctrl_response,
    output logic [31:0] ctrl_event_actual,
    // Outstanding request-queue commands
    input wire logic cmd_start,
    input wire logic [63:0] cmd_start_lun,
    input wire logic [63:0] cmd_start_id,
    input wire logic cmd_finish,
    input wire logic [$clog2(SLOTS)-1:0] cmd_finish_slot,
    output logic cmd_complete,
    output logic [$clog2(SLOTS)-1:0] cmd_complete_slot,
    output logic [7:0] cmd_complete_response,
    // Event sources
    input wire logic evt_valid,
    input wire logic [31:0] evt_code,
    input wire logic [63:0] evt_lun,
    input wire logic [31:0] evt_reason,
    input wire logic [4:0] evt_periph_type,
    input wire logic evt_buf_avail,
    input wire logic evt_buf_short,
    output logic evt_write,
    output logic [31:0] evt_out_code,
    output logic [63:0] evt_out_lun,
    output logic [31:0] evt_out_reason,
    // Sense data to attach to a unit
    output logic sense_valid,
    output logic [63:0] sense_lun,
    output logic [3:0] sense_key,
    output logic [7:0] sense_asc,
    output logic [7:0] sense_ascq
);
    localparam int SW = $clog2(SLOTS);
    localparam int UW = $clog2(UNITS);

    // Drain must fit the answer bound; unit index must stay inside the mask table
    if (SLOTS < 2 || SLOTS > 32 || UNITS < 2 || UNITS > 256 ||
        (UNITS & (UNITS - 1)) != 0) begin : g_bad_size
        $error("scq_ctrl_event: unsupported SLOTS or UNITS");
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] type_le;
    logic [31:0] sub_le;
    logic [31:0] req_le;
    logic [31:0] actual_guest;
    logic [31:0] next_actual;

    scq_byte_order u_type (.legacy(legacy), .guest_big_endian(guest_big_endian),
        .value_in(ctrl_type), .value_out(type_le));
    scq_byte_order u_sub (.legacy(legacy), .guest_big_endian(guest_big_endian),
        .value_in(ctrl_subtype), .value_out(sub_le));
    scq_byte_order u_req (.legacy(legacy), .guest_big_endian(guest_big_endian),
        .value_in(ctrl_event_requested), .value_out(req_le));
    scq_byte_order u_act (.legacy(legacy), .guest_big_endian(guest_big_endian),
        .value_in(next_actual), .value_out(actual_guest));

    // compare address, target only for nexus-wide functions
    function automatic logic lun_match(input logic [63:0] a, input logic [63:0] b,
                                       input logic whole_nexus);
        if (whole_nexus) begin
            lun_match = (a[15:8] == b[15:8]);
        end else begin
            lun_match = (a[31:8] == b[31:8]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Outstanding command table
    logic [SLOTS-1:0] slot_busy;
    logic [63:0] slot_lun [SLOTS];
    logic [63:0] slot_id [SLOTS];
    logic [SW-1:0] alloc_slot;
    logic alloc_ok;
    logic [SLOTS-1:0] hit;
    logic [SLOTS-1:0] kill;
    scq_ctrl_e state;
    logic [SW-1:0] scan_idx;
    logic [7:0] kill_code;
    logic [31:0] op_type;
    logic [31:0] op_sub;
    logic [63:0] op_lun;
    logic [63:0] op_id;
    logic [31:0] op_req;
    logic op_nexus;

    always_comb begin
        alloc_slot = '0;
        alloc_ok = 1'b0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (!slot_busy[i]) begin
                alloc_slot = SW'(i);
                alloc_ok = 1'b1;
            end
        end
    end

    generate
        for (genvar g = 0; g < SLOTS; g++) begin : g_match
            assign hit[g] = slot_busy[g] && lun_match(slot_lun[g], op_lun, op_nexus) &&
                ((op_sub != `SCQ_TMF_ABORT_TASK && op_sub != `SCQ_TMF_QUERY_TASK) ||
                 slot_id[g] == op_id);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            slot_busy <= '0;
        end else begin
            if (cmd_start && alloc_ok) begin
                slot_busy[alloc_slot] <= 1'b1;
                slot_lun[alloc_slot] <= cmd_start_lun;
                slot_id[alloc_slot] <= cmd_start_id;
            end
            if (cmd_finish) begin
                slot_busy[cmd_finish_slot] <= 1'b0;
            end
            if (state == SCQ_DRAIN && kill[scan_idx]) begin
                slot_busy[scan_idx] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control queue engine
    logic [31:0] sub_mask [UNITS];
    logic [UW-1:0] op_unit;
    assign op_unit = op_lun[8+UW-1:8];

    always_comb begin
        next_actual = supported_events;
        // one-hot masks, reported as supported subset except for task management
        if (op_type != `SCQ_TYPE_TASK_MGMT) begin
            next_actual = supported_events & op_req;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= SCQ_IDLE;
            scan_idx <= '0;
            kill <= '0;
            kill_code <= `SCQ_RESP_RESET;
            ctrl_done <= 1'b0;
            ctrl_response <= `SCQ_RESP_OK;
            ctrl_event_actual <= '0;
            cmd_complete <= 1'b0;
            cmd_complete_slot <= '0;
            cmd_complete_response <= `SCQ_RESP_OK;
            op_type <= '0;
            op_sub <= '0;
            op_lun <= '0;
            op_id <= '0;
            op_req <= '0;
            op_nexus <= 1'b0;
            for (int u = 0; u < UNITS; u++) begin
                sub_mask[u] <= '0;
            end
        end else begin
            ctrl_done <= 1'b0;
            cmd_complete <= 1'b0;
            case (state)
                SCQ_IDLE: begin
                    if (ctrl_valid) begin
                        op_type <= type_le;
                        op_sub <= sub_le;
                        op_lun <= ctrl_lun;
                        op_id <= ctrl_id;
                        op_req <= req_le;
                        op_nexus <= (sub_le == `SCQ_TMF_IT_NEXUS_RESET);
                        state <= SCQ_SCAN;
                    end
                end
                SCQ_SCAN: begin
                    kill <= '0;
                    scan_idx <= '0;
                    state <= SCQ_RESPOND;
                    if (op_type == `SCQ_TYPE_TASK_MGMT) begin
                        if (op_sub == `SCQ_TMF_UNIT_RESET || op_sub == `SCQ_TMF_IT_NEXUS_RESET ||
                            op_sub == `SCQ_TMF_CLEAR_TASK_SET) begin
                            kill <= hit;
                            kill_code <= `SCQ_RESP_RESET;
                            state <= SCQ_DRAIN;
                        end else if (op_sub == `SCQ_TMF_ABORT_TASK ||
                                     op_sub == `SCQ_TMF_ABORT_TASK_SET) begin
                            kill <= hit;
                            kill_code <= `SCQ_RESP_ABORTED;
                            state <= SCQ_DRAIN;
                        end
                    end
                end
                // one completion per killed slot before the function answer
                SCQ_DRAIN: begin
                    if (kill[scan_idx]) begin
                        cmd_complete <= 1'b1;
                        cmd_complete_slot <= scan_idx;
                        cmd_complete_response <= kill_code;
                    end
                    if (scan_idx == SW'(SLOTS - 1)) begin
                        state <= SCQ_RESPOND;
                    end
                    scan_idx <= scan_idx + 1'b1;
                end
                SCQ_RESPOND: begin
                    ctrl_done <= 1'b1;
                    ctrl_event_actual <= actual_guest;
                    state <= SCQ_IDLE;
                    if (op_type == `SCQ_TYPE_TASK_MGMT) begin
                        if (op_sub > `SCQ_TMF_QUERY_TASK_SET) begin
                            ctrl_response <= `SCQ_RESP_FUNC_REJECTED;
                        end else if ((op_sub == `SCQ_TMF_QUERY_TASK ||
                                      op_sub == `SCQ_TMF_QUERY_TASK_SET) && hit == '0) begin
                            ctrl_response <= `SCQ_RESP_FUNC_COMPLETE;
                        end else begin
                            ctrl_response <= `SCQ_RESP_FUNC_COMPLETE;
                        end
                    end else if (op_type == `SCQ_TYPE_AN_QUERY) begin
                        ctrl_response <= `SCQ_RESP_OK;
                    end else if (op_type == `SCQ_TYPE_AN_SUBSCRIBE) begin
                        ctrl_response <= `SCQ_RESP_OK;
                        sub_mask[op_unit] <= next_actual;
                    end else begin
                        ctrl_response <= `SCQ_RESP_FAILURE;
                    end
                end
                default: state <= SCQ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event queue
    logic lost;
    logic evt_allowed;
    logic [31:0] evt_reason_out;
    logic [UW-1:0] evt_unit;
    logic [31:0] code_g;
    logic [31:0] reason_g;
    assign evt_unit = evt_lun[8+UW-1:8];

    always_comb begin
        evt_allowed = 1'b1;
        evt_reason_out = evt_reason;
        if (evt_code == `SCQ_EVT_UNIT_RESET) begin
            evt_allowed = (evt_reason == `SCQ_REASON_HARD) ||
                (hot_plug_feature && (evt_reason == `SCQ_REASON_RESCAN ||
                                      evt_reason == `SCQ_REASON_REMOVED));
        end else if (evt_code == `SCQ_EVT_ASYNC_NOTIFY) begin
            evt_reason_out = evt_reason & sub_mask[evt_unit];
            evt_allowed = (evt_reason_out != '0);
        end else if (evt_code == `SCQ_EVT_PARAM_CHANGE) begin
            // asc in low byte, ascq next
            evt_reason_out = {16'h0000, evt_reason[15:0]};
            evt_allowed = (evt_periph_type != `SCQ_PERIPH_MULTIMEDIA);
        end else begin
            evt_allowed = 1'b0;
        end
    end

    scq_byte_order u_code (.legacy(legacy), .guest_big_endian(guest_big_endian),
        .value_in((evt_buf_short || !(evt_valid && evt_allowed)) ?
                  (`SCQ_EVT_NONE | (lost ? `SCQ_LOST_EVENTS_FLAG : 32'h0000_0000)) :
                  (evt_code | (lost ? `SCQ_LOST_EVENTS_FLAG : 32'h0000_0000))),
        .value_out(code_g));
    scq_byte_order u_reason (.legacy(legacy), .guest_big_endian(guest_big_endian),
        .value_in(evt_buf_short ? 32'h0000_0000 : evt_reason_out), .value_out(reason_g));

    always_ff @(posedge clk) begin
        if (reset) begin
            lost <= 1'b0;
            evt_write <= 1'b0;
            evt_out_code <= '0;
            evt_out_lun <= '0;
            evt_out_reason <= '0;
        end else begin
            evt_write <= 1'b0;
            if (evt_buf_avail && ((evt_valid && evt_allowed) || lost || evt_buf_short)) begin
                // flag losses; dummy code for short buffer or loss
                evt_write <= 1'b1;
                evt_out_code <= code_g;
                evt_out_lun <= evt_buf_short ? 64'h0 : evt_lun;
                evt_out_reason <= reason_g;
                // Set wins: an event squeezed out by a short buffer is lost too
                lost <= evt_buf_short && evt_valid && evt_allowed;
            end else if (evt_valid && evt_allowed && !evt_buf_avail) begin
                lost <= 1'b1;
            end
        end
    end

    // reset events also as sense data
    always_ff @(posedge clk) begin
        if (reset) begin
            sense_valid <= 1'b0;
            sense_lun <= '0;
            sense_key <= '0;
            sense_asc <= '0;
            sense_ascq <= '0;
        end else begin
            sense_valid <= evt_valid && evt_allowed &&
                (evt_code == `SCQ_EVT_UNIT_RESET || evt_code == `SCQ_EVT_PARAM_CHANGE);
            sense_lun <= evt_lun;
            sense_ascq <= `SCQ_ASCQ_ZERO;
            if (evt_code == `SCQ_EVT_PARAM_CHANGE) begin
                sense_key <= `SCQ_KEY_UNIT_ATTENTION;
                sense_asc <= evt_reason[7:0];
                sense_ascq <= evt_reason[15:8];
            end else if (evt_reason == `SCQ_REASON_REMOVED) begin
                sense_key <= `SCQ_KEY_ILLEGAL_REQUEST;
                sense_asc <= `SCQ_ASC_NOT_SUPPORTED;
            end else if (evt_reason == `SCQ_REASON_RESCAN) begin
                sense_key <= `SCQ_KEY_UNIT_ATTENTION;
                sense_asc <= `SCQ_ASC_LUNS_CHANGED;
                sense_ascq <= `SCQ_ASCQ_LUNS_CHANGED;
            end else begin
                sense_key <= `SCQ_KEY_UNIT_ATTENTION;
                sense_asc <= `SCQ_ASC_RESET_OCCURRED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_lost_flag_set: assert property (@(posedge clk) disable iff (reset)
        (lost && evt_buf_avail) |=> (evt_write && (legacy || evt_out_code[31])))
        else $error("lost events not flagged");
    a_drain_before_done: assert property (@(posedge clk) disable iff (reset)
        cmd_complete |-> !ctrl_done)
        else $error("completion overlapped response");
    a_no_hotplug: assert property (@(posedge clk) disable iff (reset)
        (evt_valid && evt_code == `SCQ_EVT_UNIT_RESET && evt_reason != `SCQ_REASON_HARD
         && !hot_plug_feature && !lost && !evt_buf_short) |=> !evt_write)
        else $error("hot-plug event without feature");
    a_no_mm_param: assert property (@(posedge clk) disable iff (reset)
        (evt_valid && evt_code == `SCQ_EVT_PARAM_CHANGE &&
         evt_periph_type == `SCQ_PERIPH_MULTIMEDIA && !lost && !evt_buf_short) |=> !evt_write)
        else $error("param change for multimedia unit");
    a_drop_sets_lost: assert property (@(posedge clk) disable iff (reset)
        (evt_valid && evt_allowed && !evt_buf_avail) |=> lost)
        else $error("drop not remembered");
    a_done_bounded: assert property (@(posedge clk) disable iff (reset)
        (state == SCQ_IDLE && ctrl_valid) |-> ##[2:40] ctrl_done)
        else $error("control request not answered");
    a_reset_code: assert property (@(posedge clk) disable iff (reset)
        (cmd_complete && (op_sub == `SCQ_TMF_UNIT_RESET)) |-> cmd_complete_response
        == `SCQ_RESP_RESET)
        else $error("wrong reset completion code");
    a_abort_code: assert property (@(posedge clk) disable iff (reset)
        (cmd_complete && (op_sub == `SCQ_TMF_ABORT_TASK || op_sub == `SCQ_TMF_ABORT_TASK_SET))
        |-> cmd_complete_response
        == `SCQ_RESP_ABORTED)
        else $error("wrong abort completion code");
    c_abort: cover property (@(posedge clk) cmd_complete && cmd_complete_response ==
        `SCQ_RESP_ABORTED);
    c_lost: cover property (@(posedge clk) evt_write && lost);
    c_subscribe: cover property (@(posedge clk) ctrl_done && op_type ==
        `SCQ_TYPE_AN_SUBSCRIBE);
endmodule

// ### shared/scq_defines.svh
`ifndef SCQ_DEFINES_SVH
`define SCQ_DEFINES_SVH
// Control request types
`define SCQ_TYPE_TASK_MGMT 32'h0000_0000
`define SCQ_TYPE_AN_QUERY 32'h0000_0001
`define SCQ_TYPE_AN_SUBSCRIBE 32'h0000_0002
// Task management subtypes
`define SCQ_TMF_ABORT_TASK 32'h0000_0000
`define SCQ_TMF_ABORT_TASK_SET 32'h0000_0001
`define SCQ_TMF_CLEAR_ACA 32'h0000_0002
`define SCQ_TMF_CLEAR_TASK_SET 32'h0000_0003
`define SCQ_TMF_IT_NEXUS_RESET 32'h0000_0004
`define SCQ_TMF_UNIT_RESET 32'h0000_0005
`define SCQ_TMF_QUERY_TASK 32'h0000_0006
`define SCQ_TMF_QUERY_TASK_SET 32'h0000_0007
// Async notify event bits
`define SCQ_AN_OPERATIONAL_CHANGE 32'h0000_0002
`define SCQ_AN_POWER_MGMT 32'h0000_0004
`define SCQ_AN_EXTERNAL_REQUEST 32'h0000_0008
`define SCQ_AN_MEDIA_CHANGE 32'h0000_0010
`define SCQ_AN_MULTI_HOST 32'h0000_0020
`define SCQ_AN_DEVICE_BUSY 32'h0000_0040
// Response codes
`define SCQ_RESP_OK 8'h00
`define SCQ_RESP_ABORTED 8'h02
`define SCQ_RESP_BAD_TARGET 8'h03
`define SCQ_RESP_RESET 8'h04
`define SCQ_RESP_FAILURE 8'h09
`define SCQ_RESP_FUNC_COMPLETE 8'h00
`define SCQ_RESP_FUNC_REJECTED 8'h0b
// Event codes and reasons
`define SCQ_EVT_NONE 32'h0000_0000
`define SCQ_EVT_UNIT_RESET 32'h0000_0001
`define SCQ_EVT_ASYNC_NOTIFY 32'h0000_0002
`define SCQ_EVT_PARAM_CHANGE 32'h0000_0003
`define SCQ_LOST_EVENTS_FLAG 32'h8000_0000
`define SCQ_REASON_HARD 32'h0000_0000
`define SCQ_REASON_RESCAN 32'h0000_0001
`define SCQ_REASON_REMOVED 32'h0000_0002
`define SCQ_PERIPH_MULTIMEDIA 5'h05
// Sense data
`define SCQ_KEY_ILLEGAL_REQUEST 4'h5
`define SCQ_KEY_UNIT_ATTENTION 4'h6
`define SCQ_ASC_NOT_SUPPORTED 8'h25
`define SCQ_ASC_RESET_OCCURRED 8'h29
`define SCQ_ASC_LUNS_CHANGED 8'h3f
`define SCQ_ASCQ_ZERO 8'h00
`define SCQ_ASCQ_LUNS_CHANGED 8'h0e
// Unit address format
`define SCQ_LUN_FORMAT_BYTE 8'h01
`endif

// ### shared/scq_pkg.sv
package scq_pkg;
    typedef enum logic [2:0] {
        SCQ_IDLE,
        SCQ_SCAN,
        SCQ_DRAIN,
        SCQ_RESPOND
    } scq_ctrl_e;
    typedef logic [63:0] scq_lun_t;
endpackage

// ### verilog/scq_byte_order.sv
`timescale 1ns/100ps
// Swaps a 32-bit field between little-endian and guest order
module scq_byte_order
    import scq_pkg::*;
(
    input wire logic legacy,
    input wire logic guest_big_endian,
    input wire logic [31:0] value_in,
    output logic [31:0] value_out
);
    always_comb begin
        if (legacy && guest_big_endian) begin
            value_out = {value_in[7:0], value_in[15:8], value_in[23:16], value_in[31:24]};
        end else begin
            value_out = value_in;
        end
    end
endmodule

// ### verification/scq_guest_model.sv
`timescale 1ns/100ps
module scq_guest_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic post,
    input wire logic [3:0] post_count,
    input wire logic evt_write,
    output logic evt_buf_avail
);
    logic [3:0] posted;
    always_ff @(posedge clk) begin
        if (reset) begin
            posted <= 4'h0;
        end else if (post) begin
            posted <= post_count;
        end else if (evt_write && posted != 4'h0) begin
            posted <= posted - 4'h1;
        end
    end
    // A buffer taken by the write in flight is already gone
    assign evt_buf_avail = posted > (evt_write ? 4'h1 : 4'h0);
endmodule

// ### verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clk, reset, legacy, guest_big_endian, hot_plug_feature, ctrl_valid, cmd_start;
    logic cmd_finish, evt_valid, evt_buf_avail, evt_buf_short, post, ctrl_done, cmd_complete;
    logic evt_write, sense_valid, done_seen;
    logic [31:0] supported_events, ctrl_type, ctrl_subtype, ctrl_event_requested, evt_code;
    logic [31:0] evt_reason, ctrl_event_actual, evt_out_code, evt_out_reason, actual, w_code, w_rsn;
    logic [63:0] ctrl_lun, ctrl_id, cmd_start_lun, cmd_start_id, evt_lun, evt_out_lun, sense_lun;
    logic [63:0] w_lun;
    logic [3:0] cmd_finish_slot, cmd_complete_slot, post_count, sense_key, s_key, k_slot;
    logic [7:0] ctrl_response, cmd_complete_response, sense_asc, sense_ascq, resp, k_resp, s_asc;
    logic [7:0] s_ascq;
    logic [4:0] evt_periph_type;
    int err_count, n_tests, cycles, n_kill, kill_done, n_wr, k0;
    localparam logic [63:0] LA = 64'h0000_0000_0000_0301;
    localparam logic [63:0] LB = 64'h0000_0000_0005_0401;
    scq_ctrl_event i_dut (.clk, .reset, .legacy, .guest_big_endian, .hot_plug_feature,
        .supported_events, .ctrl_valid, .ctrl_type, .ctrl_subtype, .ctrl_lun, .ctrl_id,
        .ctrl_event_requested, .ctrl_done, .ctrl_response, .ctrl_event_actual, .cmd_start,
        .cmd_start_lun, .cmd_start_id, .cmd_finish, .cmd_finish_slot, .cmd_complete,
        .cmd_complete_slot, .cmd_complete_response, .evt_valid, .evt_code, .evt_lun, .evt_reason,
        .evt_periph_type, .evt_buf_avail, .evt_buf_short, .evt_write, .evt_out_code, .evt_out_lun,
        .evt_out_reason, .sense_valid, .sense_lun, .sense_key, .sense_asc, .sense_ascq);
    scq_guest_model i_guest (.clk, .reset, .post, .post_count, .evt_write, .evt_buf_avail);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cmd_complete) begin
            n_kill++;
            k_resp = cmd_complete_response;
            k_slot = cmd_complete_slot;
        end
        if (ctrl_done) begin
            done_seen = 1;
            kill_done = n_kill;
            resp = ctrl_response;
            actual = ctrl_event_actual;
        end
        if (evt_write) begin
            n_wr++;
            {w_code, w_lun, w_rsn} = {evt_out_code, evt_out_lun, evt_out_reason};
        end
        if (sense_valid) begin
            {s_key, s_asc, s_ascq} = {sense_key, sense_asc, sense_ascq};
        end
        if (cycles == 6000) begin
            err_count++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ctrl(input logic [31:0] t, st, input logic [63:0] lun, id,
                        input logic [31:0] req);
        int i;
        done_seen = 0;
        @(posedge clk);
        {ctrl_valid, ctrl_type, ctrl_subtype, ctrl_lun, ctrl_id} <= {1'b1, t, st, lun, id};
        ctrl_event_requested <= req;
        @(posedge clk);
        ctrl_valid <= 0;
        for (i = 0; i < 40 && !done_seen; i++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task automatic cmd(input logic [63:0] lun, id);
        @(posedge clk);
        {cmd_start, cmd_start_lun, cmd_start_id} <= {1'b1, lun, id};
        @(posedge clk);
        cmd_start <= 0;
    endtask
    task automatic evt(input logic [31:0] c, r, input logic [4:0] pt);
        @(posedge clk);
        {evt_valid, evt_code, evt_reason, evt_lun, evt_periph_type} <= {1'b1, c, r, LA, pt};
        @(posedge clk);
        evt_valid <= 0;
        post <= 0;
        repeat (4) @(posedge clk);
    endtask
    task automatic finish_test;
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, legacy, guest_big_endian, hot_plug_feature, post, evt_buf_short} = 6'h20;
        {ctrl_valid, cmd_start, cmd_finish, evt_valid, cmd_finish_slot, post_count} = '0;
        {ctrl_type, ctrl_subtype, ctrl_lun, ctrl_id, ctrl_event_requested} = '0;
        {cmd_start_lun, cmd_start_id, evt_code, evt_reason, evt_lun, evt_periph_type} = '0;
        supported_events = 32'h0000_0012;
        repeat (3) @(posedge clk);
        reset <= 0;
        ctrl(32'h1, 0, LA, 0, 32'h16);
        chk(resp, 8'h00, "query resp");
        chk(actual, 32'h12, "query mask");
        ctrl(32'h2, 0, LA, 0, 32'h10);
        chk(actual, 32'h10, "subscribe mask");
        for (int s = 0; s < 9; s++) begin
            ctrl(0, s, LA, 64'h99, 32'hffff);
            chk(resp, s < 8 ? 8'h00 : 8'h0b, "tmf resp");
        end
        cmd(LA, 64'h1);
        cmd(LA, 64'h2);
        cmd(LB, 64'h3);
        k0 = n_kill;
        ctrl(0, 5, LA, 0, 0);
        chk(n_kill - k0, 2, "reset kills");
        chk(k_resp, 8'h04, "reset code");
        chk(kill_done - k0, 2, "kills before done");
        cmd(LA, 64'h7);
        k0 = n_kill;
        ctrl(0, 0, LA, 64'h7, 0);
        chk(n_kill - k0, 1, "abort kills");
        chk({k_resp, k_slot}, {8'h02, 4'h0}, "abort code");
        {cmd_finish, cmd_finish_slot} <= {1'b1, 4'h2};
        @(posedge clk) cmd_finish <= 0;
        k0 = n_kill;
        ctrl(0, 1, LB, 0, 0);
        chk(n_kill - k0, 0, "finished slot");
        k0 = n_wr;
        evt(32'h3, 32'h092a, 0);
        chk(n_wr - k0, 0, "dropped");
        {post, post_count} <= {1'b1, 4'h8};
        evt(32'h3, 32'h092a, 0);
        chk({w_code, w_rsn}, {32'h8000_0003, 32'h092a}, "lost flag");
        chk({s_key, s_asc, s_ascq}, {4'h6, 8'h2a, 8'h09}, "param sense");
        evt(32'h1, 32'h0, 0);
        chk({w_code, w_rsn, s_key, s_asc}, {32'h1, 32'h0, 4'h6, 8'h29}, "hard reset");
        k0 = n_wr;
        evt(32'h3, 32'h092a, 5'h05);
        evt(32'h1, 32'h2, 0);
        chk(n_wr - k0, 0, "suppressed");
        hot_plug_feature <= 1;
        evt(32'h1, 32'h2, 0);
        chk({w_rsn, s_key, s_asc, s_ascq}, {32'h2, 20'h52500}, "removed");
        chk(sense_lun, LA, "sense unit");
        evt(32'h2, 32'h12, 0);
        chk({w_code, w_lun, w_rsn}, {32'h2, LA, 32'h10}, "async");
        evt_buf_short <= 1;
        evt(32'h1, 32'h0, 0);
        chk({w_code, w_lun, w_rsn}, 128'h0, "short buffer");
        {evt_buf_short, legacy, guest_big_endian} <= 3'h3;
        ctrl(32'h0100_0000, 0, LA, 0, 32'h1600_0000);
        chk(actual, 32'h1200_0000, "swapped mask");
        finish_test;
    end
endmodule
